// ==== supply_flag_pkg.sv ====
// constants and carrier types for the supply fault flag registers
// assumes word bit n maps to documented register bit n+8
package supply_flag_pkg;

  localparam int unsigned flag_width = 16;
  localparam int unsigned doc_bit_base = 8;

  // first flag word: overtemperature flags, documented bits 13..8
  localparam int unsigned boost_overtemp_flag_pos = 5;
  localparam int unsigned buck_one_overtemp_flag_pos = 4;
  localparam int unsigned buck_two_overtemp_flag_pos = 3;
  localparam int unsigned buck_three_overtemp_flag_pos = 2;
  localparam int unsigned linear_one_overtemp_flag_pos = 1;
  localparam int unsigned linear_two_overtemp_flag_pos = 0;

  // second flag word, documented bits 23..8
  localparam int unsigned prereg_feedback_overvolt_flag_pos = 15;
  localparam int unsigned supply_undervolt_lvl7_flag_pos = 14;
  localparam int unsigned boost_on_state_pos = 13;
  localparam int unsigned buck_one_on_state_pos = 12;
  localparam int unsigned buck_two_on_state_pos = 11;
  localparam int unsigned buck_three_on_state_pos = 10;
  localparam int unsigned linear_one_on_state_pos = 9;
  localparam int unsigned linear_two_on_state_pos = 8;
  localparam int unsigned prereg_undervolt_low_flag_pos = 7;
  localparam int unsigned prereg_undervolt_high_flag_pos = 6;
  localparam int unsigned supply_undervolt_low_flag_pos = 5;
  localparam int unsigned supply_undervolt_high_flag_pos = 4;
  localparam int unsigned wake_two_level_pos = 3;
  localparam int unsigned wake_one_level_pos = 2;
  localparam int unsigned wake_two_source_flag_pos = 1;
  localparam int unsigned wake_one_source_flag_pos = 0;

  // per-bit kind masks: latched (write one clears) and live (read only)
  localparam logic [15:0] one_latched_mask = 16'h003f;
  localparam logic [15:0] one_live_mask = 16'h0000;
  localparam logic [15:0] two_latched_mask = 16'hc0f3;
  localparam logic [15:0] two_live_mask = 16'h3f0c;

  // reset values: wake-1 start with every regulator powered up
  localparam logic [15:0] one_reset = 16'h0000;
  localparam logic [15:0] two_reset = 16'h7ff5;

  // synchroniser depth for asynchronous event and state lines
  localparam int unsigned sync_depth = 3;

  typedef struct packed {
    logic [15:0] one;
    logic [15:0] two;
  } supply_flags_t;

  typedef struct packed {
    logic wr_one;
    logic wr_two;
    logic [15:0] data;
  } flag_write_t;

endpackage

// ==== supply_fault_flag_registers.sv ====
// supply fault flag registers: latched event flags and live regulator state
// assumes event and state lines are asynchronous levels from analog monitors,
// and that the serial interface delivers write-one-to-clear strobes on clock
//
// Contract
// - boost overtemp sets bit 13, else zero
// - buck overtemp flags at bits 12..10
// - linear overtemp flags at bits 9, 8
// - power-on reset or writing one clears
// - feedback OV, supply UV7, prereg UVL latch
// - bits 21..16 show live regulator state
// - reset reflects wake-1, regulators on
`timescale 1ns/1ps

module supply_fault_flag_registers
  import supply_flag_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // raw monitor lines, asynchronous
  input wire supply_flags_t monitor_raw,
  // register write strobes from the serial interface
  input wire flag_write_t flag_write,
  // register read image
  output supply_flags_t flags
);

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers on every monitor line

  localparam supply_flags_t sync_reset = '{one: one_reset, two: two_reset};
  localparam supply_flags_t latched_mask = '{one: one_latched_mask, two: two_latched_mask};
  localparam supply_flags_t live_mask = '{one: one_live_mask, two: two_live_mask};

  supply_flags_t sync_a;
  supply_flags_t sync_b;
  supply_flags_t sync_c;
  supply_flags_t next_sync_a;
  supply_flags_t next_sync_b;
  supply_flags_t next_sync_c;

  always_comb begin
    next_sync_a = monitor_raw;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
  end

  // live bits start at their reset image so the state reads one from reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= sync_reset;
      sync_b <= sync_reset;
      sync_c <= sync_reset;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filtered monitor levels

  // word one occupies the upper half of the flat image, word two the lower
  localparam logic [31:0] lat_bits = latched_mask;
  localparam logic [31:0] live_bits = live_mask;

  logic [31:0] b_bits;
  logic [31:0] c_bits;
  logic [31:0] settled;
  logic [31:0] level;

  assign b_bits = sync_b;
  assign c_bits = sync_c;
  // a line counts only once stages two and three agree
  assign settled = ~(b_bits ^ c_bits);
  assign level = b_bits & c_bits;

  ////////////////////////////////////////////////////////////////////////////
  // word one overtemperature shutdown events

  logic boost_overtemp_event;
  logic buck_one_overtemp_event;
  logic buck_two_overtemp_event;
  logic buck_three_overtemp_event;
  logic linear_one_overtemp_event;
  logic linear_two_overtemp_event;

  assign boost_overtemp_event = level[flag_width + boost_overtemp_flag_pos];
  assign buck_one_overtemp_event = level[flag_width + buck_one_overtemp_flag_pos];
  assign buck_two_overtemp_event = level[flag_width + buck_two_overtemp_flag_pos];
  assign buck_three_overtemp_event = level[flag_width + buck_three_overtemp_flag_pos];
  assign linear_one_overtemp_event = level[flag_width + linear_one_overtemp_flag_pos];
  assign linear_two_overtemp_event = level[flag_width + linear_two_overtemp_flag_pos];

  ////////////////////////////////////////////////////////////////////////////
  // word two latched events

  logic prereg_feedback_overvolt_event;
  logic supply_undervolt_lvl7_event;
  logic prereg_undervolt_low_event;
  logic prereg_undervolt_high_event;
  logic supply_undervolt_low_event;
  logic supply_undervolt_high_event;
  logic wake_two_source_event;
  logic wake_one_source_event;

  assign prereg_feedback_overvolt_event = level[prereg_feedback_overvolt_flag_pos];
  assign supply_undervolt_lvl7_event = level[supply_undervolt_lvl7_flag_pos];
  assign prereg_undervolt_low_event = level[prereg_undervolt_low_flag_pos];
  assign prereg_undervolt_high_event = level[prereg_undervolt_high_flag_pos];
  assign supply_undervolt_low_event = level[supply_undervolt_low_flag_pos];
  assign supply_undervolt_high_event = level[supply_undervolt_high_flag_pos];
  assign wake_two_source_event = level[wake_two_source_flag_pos];
  assign wake_one_source_event = level[wake_one_source_flag_pos];

  ////////////////////////////////////////////////////////////////////////////
  // word two live levels

  logic boost_on_level;
  logic buck_one_on_level;
  logic buck_two_on_level;
  logic buck_three_on_level;
  logic linear_one_on_level;
  logic linear_two_on_level;
  logic wake_two_now;
  logic wake_one_now;

  // regulator on state, stage three level
  assign boost_on_level = c_bits[boost_on_state_pos];
  assign buck_one_on_level = c_bits[buck_one_on_state_pos];
  assign buck_two_on_level = c_bits[buck_two_on_state_pos];
  assign buck_three_on_level = c_bits[buck_three_on_state_pos];
  assign linear_one_on_level = c_bits[linear_one_on_state_pos];
  assign linear_two_on_level = c_bits[linear_two_on_state_pos];
  assign wake_two_now = c_bits[wake_two_level_pos];
  assign wake_one_now = c_bits[wake_one_level_pos];

  ////////////////////////////////////////////////////////////////////////////
  // set, live and clear images

  logic [31:0] set_bits;
  logic [31:0] live_level;
  logic [31:0] clear_ones;
  logic [31:0] cur_bits;
  wire logic [31:0] next_bits;
  supply_flags_t next_flags;

  assign set_bits = {
    10'h000,
    boost_overtemp_event,
    buck_one_overtemp_event,
    buck_two_overtemp_event,
    buck_three_overtemp_event,
    linear_one_overtemp_event,
    linear_two_overtemp_event,
    prereg_feedback_overvolt_event,
    supply_undervolt_lvl7_event,
    6'h00,
    prereg_undervolt_low_event,
    prereg_undervolt_high_event,
    supply_undervolt_low_event,
    supply_undervolt_high_event,
    2'h0,
    wake_two_source_event,
    wake_one_source_event
  };

  assign live_level = {
    16'h0000,
    2'h0,
    boost_on_level,
    buck_one_on_level,
    buck_two_on_level,
    buck_three_on_level,
    linear_one_on_level,
    linear_two_on_level,
    4'h0,
    wake_two_now,
    wake_one_now,
    2'h0
  };

  assign cur_bits = flags;
  // both strobes in one cycle clear both words with the same data
  assign clear_ones = {flag_write.wr_one ? flag_write.data : 16'h0000,
                       flag_write.wr_two ? flag_write.data : 16'h0000};

  ////////////////////////////////////////////////////////////////////////////
  // per-bit next value

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (lat_bits[i]) begin : g_latched
        // event latch; a set in the clear cycle wins
        // write one clears, zero leaves alone
        assign next_bits[i] = (cur_bits[i] & ~clear_ones[i]) | set_bits[i];
      end else if (live_bits[i]) begin : g_live
        // live state, follows filtered line, writes ignored
        assign next_bits[i] = settled[i] ? live_level[i] : cur_bits[i];
      end else begin : g_unused
        // unused positions always read zero
        assign next_bits[i] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    next_flags = next_bits;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= sync_reset;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ==== supply_fault_flag_registers_monitor.sv ====
// assertions on the supply flag register ports
// assumes bind onto the flag register module
`timescale 1ns/1ps
module supply_fault_flag_registers_monitor
  import supply_flag_pkg::*;
(
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire supply_flags_t monitor_raw,
  input wire flag_write_t flag_write,
  input wire supply_flags_t flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_boost_set: assert property (monitor_raw.one[5] [*4] |=> flags.one[5])
    else $error("boost flag");
  a_buck_set: assert property ((&monitor_raw.one[4:2]) [*4] |=> &flags.one[4:2])
    else $error("buck flags");
  a_lin_set: assert property ((&monitor_raw.one[1:0]) [*4] |=> &flags.one[1:0])
    else $error("linear flags");
  a_one_clear: assert property ((!monitor_raw.one[5]) [*4] ##0
    (flag_write.wr_one && flag_write.data[5]) |=> !flags.one[5]) else $error("clear");
  a_fb_set: assert property (monitor_raw.two[15] [*4] |=> flags.two[15])
    else $error("feedback flag");
  a_live_follow: assert property ($stable(monitor_raw.two[13:8]) [*4] |=>
    flags.two[13:8] == $past(monitor_raw.two[13:8])) else $error("live bits");
  a_reset_image: assert property ($rose(rst_n) |-> flags == {16'h0000, 16'h7ff5})
    else $error("reset image");
  a_zero_keep: assert property (flags.one[5] && flag_write.wr_one && !flag_write.data[5]
    |=> flags.one[5]) else $error("zero write");
endmodule
bind supply_fault_flag_registers supply_fault_flag_registers_monitor
  supply_fault_flag_registers_monitor_i (.clock, .rst_n, .monitor_raw, .flag_write, .flags);

// ==== supply_fault_flag_registers_test.sv ====
// self-checking bench for the supply flag registers
// assumes package, design and monitor compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
module supply_fault_flag_registers_test;
  import supply_flag_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  supply_flags_t monitor_raw = '0;
  flag_write_t flag_write = '0;
  supply_flags_t flags;
  int fails = 0;
  int comparisons = 0;
  int seed = 22665;
  logic [15:0] e1 = 16'h0000;
  logic [15:0] e2 = 16'h0000;
  supply_fault_flag_registers supply_fault_flag_registers_i (.clock, .rst_n,
    .monitor_raw, .flag_write, .flags);
  initial forever #5 clock = ~clock;
  // latched bits keep old ones, live bits follow
  function automatic logic [15:0] upd(logic [15:0] o, r, lm, lv);
    return ((o | r) & lm) | (r & lv);
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [15:0] d);
    @(negedge clock) flag_write = '{1'b1, 1'b1, d};
    @(negedge clock) flag_write = '0;
    e1 &= ~d;
    e2 &= ~(d & 16'hc0f3);
  endtask
  initial begin
    #100000 fails++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    `CHK(flags, {16'h0000, 16'h7ff5})
    repeat (5) @(negedge clock);
    wr(16'hffff);
    `CHK(flags, {e1, e2})
    for (int i = 0; i < 24; i++) begin
      monitor_raw.one = (i == 0) ? 16'h003f : 16'($random(seed)) & 16'h003f;
      monitor_raw.two = (i == 0) ? 16'hffff : 16'($random(seed));
      repeat (6) @(negedge clock);
      e1 = upd(e1, monitor_raw.one, 16'h003f, 16'h0000);
      e2 = upd(e2, monitor_raw.two, 16'hc0f3, 16'h3f0c);
      `CHK(flags, {e1, e2})
      monitor_raw = {16'h0000, monitor_raw.two & 16'h3f0c};
      repeat (5) @(negedge clock);
      wr((i == 0) ? 16'h0000 : 16'($random(seed)));
      `CHK(flags, {e1, e2})
    end
    tally_and_finish;
  end
endmodule
